// >>> core/buf_link_if.sv
// Link between buffer control and the transmit sequencer
`timescale 1ns/100ps
interface buf_link_if;
  logic start;    // Begin preparation
  logic cancel;   // Drop preparation
  logic done;     // Core reports success
  logic fail;     // Core reports error or lost arbitration
  logic in_prep;  // Preparation window
  logic busy;     // Frame on the bus
  logic idle;     // Neither preparing nor sending
  logic sof;      // Start-of-frame pulse
  logic att_ok;   // Attempt ended well
  logic att_fail; // Attempt ended badly
  modport eng (input start, cancel, done, fail,
               output in_prep, busy, idle, sof, att_ok, att_fail);
  modport ctl (output start, cancel, done, fail,
               input in_prep, busy, idle, sof, att_ok, att_fail);
endinterface

// >>> core/can_message_buffer_tx_abort.sv
// CAN message buffer with transmit request and lock-bit abort
// How it works
// - Identifier low bits sit in 7:5
// - Bit 4 set marks a remote frame
// - Data length in 3:0, at most eight
// - Writing last data byte raises transmit request when locked
// - Every buffer starts as a receive buffer
// - Lock blocks reception, reserves for transmit
// - Clearing lock cancels waiting request at once
// - Clearing lock during frame lets it finish
// - Clear in preparation alone sends page zero
// - Gap after busy protects the lock clear
`timescale 1ns/100ps
module can_message_buffer_tx_abort
  import msgbuf_pkg::*;
(
  input  wire logic        clk,             // System clock
  input  wire logic        rst,             // Async reset, high
  input  wire logic        ce,              // Clock enable
  input  wire logic [5:0]  avs_address,     // Byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Byte lanes
  output logic      [31:0] avs_readdata,    // Read data
  output logic             avs_waitrequest, // Stall
  input  wire logic        bus_idle,        // Core sees bus idle
  input  wire logic        other_pending,   // Another buffer waits
  input  wire logic        core_tx_done,    // Frame sent well
  input  wire logic        core_tx_fail,    // Error or lost arbitration
  input  wire logic [3:0]  core_rd_idx,     // Core byte index
  output logic      [7:0]  core_rd_byte,    // Core byte
  input  wire logic        rx_we,           // Received byte strobe
  input  wire logic [3:0]  rx_idx,          // Received byte index
  input  wire logic [7:0]  rx_byte,         // Received byte
  input  wire logic        rx_last,         // Message complete
  output logic             frame_start,     // Start of frame pulse
  output logic             send_page0,      // Page zero is sent
  output logic             tx_busy,         // Frame on the bus
  output logic             irq              // Interrupt, level
);
  // ======================================
  // Declarations
  buf_link_if link ();           // Sequencer link
  logic            pend;         // First wait cycle seen
  logic            lock;         // Reserved for transmit
  logic            ready;        // Transmit request pending
  logic            no_auto_retransmit;         // No automatic retransmit
  logic            retry_hold;   // Retry held back
  logic            page0;        // Defect frame in flight
  logic            irq_q;        // Interrupt register
  logic [EV_W-1:0] irq_status;   // Sticky events
  logic [EV_W-1:0] irq_mask;     // Event enables
  logic [EV_W-1:0] events;       // This cycle's events
  logic [EV_W-1:0] w1c;          // Software clear bits
  logic [31:0]     next_readdata;// Read mux
  logic [7:0]      mem_rdata;    // Store port A
  logic            acc;          // Write taken this edge
  logic            sel_mem;      // Address hits the store
  logic            sw_wr;        // Software store write
  logic            last_data_byte_wr;     // Last data byte written
  logic            ctrl_wr;      // Buffer control written
  logic            lock_clear;   // Lock written as zero
  logic            abort_now;    // Request dropped now
  logic            defect;       // Clear hit the window alone
  logic            rx_ok;        // Received byte accepted
  logic            mem_we;       // Store write strobe
  logic [3:0]      mem_widx;     // Store write index
  logic [7:0]      mem_wdata;    // Store write byte

  // ======================================
  // Byte fitting
  // Identifier and frame type pass unchanged; an oversize
  // length is pinned to eight so the core never overruns
  function automatic logic [7:0] fit_byte(input logic [3:0] idx,
                                          input logic [7:0] b);
    logic [7:0] r;
    r = b;
    if (idx == ID_LOW_IDX) begin
      r[ID_MSB:ID_LSB] = b[ID_MSB:ID_LSB];
      r[RTR_BIT]       = b[RTR_BIT];
      if (b[DLC_MSB:0] > DLC_MAX) begin
        r[DLC_MSB:0] = DLC_MAX;
      end
    end
    return r;
  endfunction

  // ======================================
  // Bus decode
  // Writes act only at the edge that shows waitrequest low
  assign acc      = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign sel_mem  = (avs_address <= OFS_LAST_DATA_BYTE) && (avs_address[1:0] == 2'h0);
  assign sw_wr    = acc && sel_mem;
  assign last_data_byte_wr = acc && (avs_address == OFS_LAST_DATA_BYTE);
  assign ctrl_wr  = acc && (avs_address == OFS_BUF_CTRL);
  assign lock_clear = ctrl_wr && !avs_writedata[LOCK_BIT];

  // ======================================
  // Abort decisions
  // A clear in the window with nobody else waiting cannot stop
  // the core; it falls back to the page zero contents
  assign defect = lock_clear && ready && link.in_prep && !other_pending;
  // Waiting request, or window with another buffer ready: drop now
  // A clear while the frame is on the bus leaves the request up
  assign abort_now = lock_clear && ready && !link.busy && !defect;
  assign link.cancel = lock_clear && ready && link.in_prep && other_pending;
  // Start only a locked, pending request while the bus rests
  assign link.start = ready && lock && !retry_hold && bus_idle && !lock_clear;
  assign link.done = core_tx_done;
  assign link.fail = core_tx_fail;

  // ======================================
  // Store write port
  // Locked buffer refuses received bytes
  assign rx_ok     = rx_we && !lock;
  // Software wins a same-cycle clash; the received byte is lost
  assign mem_we    = sw_wr || rx_ok;
  assign mem_widx  = sw_wr ? avs_address[5:2] : rx_idx;
  assign mem_wdata = fit_byte(mem_widx, sw_wr ? avs_writedata[7:0] : rx_byte);

  msg_store u_store (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .we      (mem_we),
    .widx    (mem_widx),
    .wdata   (mem_wdata),
    .ra_idx  (avs_address[5:2]),
    .ra_data (mem_rdata),
    .rb_idx  (core_rd_idx),
    .rb_data (core_rd_byte)
  );

  tx_engine u_engine (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .link (link.eng)
  );

  assign frame_start = link.sof;
  assign tx_busy     = link.busy;
  assign send_page0  = page0;
  assign irq         = irq_q;

  // ======================================
  // Bus handshake
  // Two wait cycles give the registered store time to answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend            <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      if (!avs_waitrequest) begin
        // Transfer taken; stall the next one
        avs_waitrequest <= 1'b1;
        pend            <= 1'b0;
      end else if (avs_read || avs_write) begin
        if (pend) begin
          avs_waitrequest <= 1'b0;
          pend            <= 1'b0;
        end else begin
          pend <= 1'b1;
        end
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (sel_mem) begin
      next_readdata[7:0] = mem_rdata;
    end else begin
      case (avs_address)
        OFS_BUF_CTRL: begin
          next_readdata[LOCK_BIT]  = lock;
          next_readdata[READY_BIT] = ready;
          next_readdata[BUSY_BIT]  = link.busy;
          next_readdata[PAGE0_BIT] = page0;
        end
        OFS_CTRL:       next_readdata[NO_AUTO_RETRANSMIT_BIT] = no_auto_retransmit;
        OFS_IRQ_STATUS: next_readdata[EV_W-1:0] = irq_status;
        OFS_IRQ_MASK:   next_readdata[EV_W-1:0] = irq_mask;
        default:        next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data stands from the edge before the answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && pend && avs_waitrequest && avs_read) begin
      avs_readdata <= next_readdata;
    end
  end

  // ======================================
  // Lock bit
  // Reset leaves the buffer open for reception
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock <= LOCK_RST;
    end else if (ce && ctrl_wr) begin
      lock <= avs_writedata[LOCK_BIT];
    end
  end

  // No automatic retransmit control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      no_auto_retransmit <= NO_AUTO_RETRANSMIT_RST;
    end else if (ce && acc && avs_address == OFS_CTRL) begin
      no_auto_retransmit <= avs_writedata[NO_AUTO_RETRANSMIT_BIT];
    end
  end

  // ======================================
  // Ready flag
  // A request made on an unlocked buffer is ignored, since
  // reception could overwrite it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
    end else if (ce) begin
      if (last_data_byte_wr && lock) begin
        ready <= 1'b1;
      end else if (abort_now || link.att_ok) begin
        ready <= 1'b0;
      end
      // A lock clear during a failing frame leaves ready up until
      // software clears lock once more after the attempt
    end
  end

  // Retry hold after a failed attempt without retransmit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      retry_hold <= 1'b0;
    end else if (ce) begin
      if (last_data_byte_wr || !no_auto_retransmit || !ready) begin
        retry_hold <= 1'b0;
      end else if (link.att_fail) begin
        retry_hold <= 1'b1;
      end
    end
  end

  // Page zero marker lasts through the defect frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      page0 <= 1'b0;
    end else if (ce) begin
      if (defect) begin
        page0 <= 1'b1;
      end else if (link.att_ok || link.att_fail) begin
        page0 <= 1'b0;
      end
    end
  end

  // ======================================
  // Interrupts
  assign events[EV_TX_OK] = link.att_ok;
  assign events[EV_ABORT] = abort_now;
  assign events[EV_FAIL]  = link.att_fail;
  assign events[EV_RX]    = rx_last && !lock;
  assign w1c = (acc && avs_address == OFS_IRQ_STATUS) ?
               avs_writedata[EV_W-1:0] : '0;

  // Sticky status; a new event beats its own clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
    end else if (ce) begin
      irq_status <= (irq_status & ~w1c) | events;
    end
  end

  // Mask register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask <= MASK_RST;
    end else if (ce && acc && avs_address == OFS_IRQ_MASK) begin
      irq_mask <= avs_writedata[EV_W-1:0];
    end
  end

  // Level output, one cycle behind status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(irq_status & irq_mask);
    end
  end

  // ======================================
  // Checks
  sequence s_lock_clear;
    lock_clear && ready;
  endsequence

  property p_request;
    @(posedge clk) disable iff (rst || !ce) last_data_byte_wr && lock |=> ready;
  endproperty
  a_request: assert property (p_request) else $error("request not raised");

  property p_rx_block;
    @(posedge clk) disable iff (rst || !ce) rx_we && lock |-> !mem_we || sw_wr;
  endproperty
  a_rx_block: assert property (p_rx_block) else $error("locked buffer took rx");

  property p_abort_idle;
    @(posedge clk) disable iff (rst || !ce)
      s_lock_clear ##0 link.idle |=> !ready && irq_status[EV_ABORT];
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort not at once");

  property p_keep_busy;
    @(posedge clk) disable iff (rst || !ce)
      s_lock_clear ##0 (link.busy && !link.done && !link.fail) |=>
        ready && !lock && link.busy;
  endproperty
  a_keep_busy: assert property (p_keep_busy) else $error("frame was cut");

  property p_defect;
    @(posedge clk) disable iff (rst || !ce)
      s_lock_clear ##0 (link.in_prep && !other_pending) |=> page0 && !lock && ready;
  endproperty
  a_defect: assert property (p_defect) else $error("defect path missed");

  property p_release;
    @(posedge clk) disable iff (rst || !ce) link.att_ok && !last_data_byte_wr |=> !ready;
  endproperty
  a_release: assert property (p_release) else $error("ready not released");

  property p_dlc;
    @(posedge clk) disable iff (rst || !ce)
      mem_we && mem_widx == ID_LOW_IDX |-> mem_wdata[DLC_MSB:0] <= DLC_MAX;
  endproperty
  a_dlc: assert property (p_dlc) else $error("length above eight stored");
endmodule

// >>> core/msg_store.sv
// Nine-byte message store with two registered read ports
`timescale 1ns/100ps
module msg_store
  import msgbuf_pkg::*;
(
  input  wire logic       clk,    // System clock
  input  wire logic       rst,    // Async reset, high
  input  wire logic       ce,     // Clock enable
  input  wire logic       we,     // Write strobe
  input  wire logic [3:0] widx,   // Write index
  input  wire logic [7:0] wdata,  // Write byte
  input  wire logic [3:0] ra_idx, // Port A index
  output logic      [7:0] ra_data,// Port A byte
  input  wire logic [3:0] rb_idx, // Port B index
  output logic      [7:0] rb_data // Port B byte
);
  logic [7:0] mem [BUF_BYTES];    // Contents, undefined after reset

  // Array holds no reset, like the buffer it models
  always_ff @(posedge clk) begin
    if (ce && we && widx < BUF_BYTES) begin
      mem[widx] <= wdata;
    end
  end

  // Read registers; out of range reads give zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ra_data <= 8'h00;
      rb_data <= 8'h00;
    end else if (ce) begin
      ra_data <= (ra_idx < BUF_BYTES) ? mem[ra_idx] : 8'h00;
      rb_data <= (rb_idx < BUF_BYTES) ? mem[rb_idx] : 8'h00;
    end
  end
endmodule

// >>> core/msgbuf_pkg.sv
// Shared constants and types for the CAN message buffer block
package msgbuf_pkg;
  // ======================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;   // 40 MHz system clock
  localparam int BIT_TIME_NS   = 2000; // Nominal CAN bit time
  localparam int BIT_CYCLES    = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PREP_BITS     = 2;    // Preparation before start of frame
  localparam int SPACE_BITS    = 3;    // Quiet gap after each attempt
  localparam int CNT_W         = 9;    // Countdown width
  localparam logic [CNT_W-1:0] PREP_LAST  = CNT_W'(PREP_BITS * BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] SPACE_LAST = CNT_W'(SPACE_BITS * BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE    = 9'h001;
  // ======================================
  // Register byte offsets
  localparam logic [5:0] OFS_ID_LOW     = 6'h00;
  localparam logic [5:0] OFS_LAST_DATA_BYTE      = 6'h20;
  localparam logic [5:0] OFS_BUF_CTRL   = 6'h24;
  localparam logic [5:0] OFS_CTRL       = 6'h28;
  localparam logic [5:0] OFS_IRQ_STATUS = 6'h2C;
  localparam logic [5:0] OFS_IRQ_MASK   = 6'h30;
  // ======================================
  // Field positions
  localparam int ID_MSB    = 7;   // Identifier low bits 7:5
  localparam int ID_LSB    = 5;
  localparam int RTR_BIT   = 4;   // Remote frame marker
  localparam int DLC_MSB   = 3;   // Data length 3:0
  localparam logic [3:0] DLC_MAX = 4'h8;
  localparam int LOCK_BIT  = 0;   // Buffer control fields
  localparam int READY_BIT = 1;
  localparam int BUSY_BIT  = 2;
  localparam int PAGE0_BIT = 3;
  localparam int NO_AUTO_RETRANSMIT_BIT  = 0;   // Controller control field
  localparam int EV_W      = 4;   // Event bits
  localparam int EV_TX_OK  = 0;
  localparam int EV_ABORT  = 1;
  localparam int EV_FAIL   = 2;
  localparam int EV_RX     = 3;
  // ======================================
  // Buffer layout and reset values
  localparam int BUF_BYTES = 9;   // Identifier low plus eight data
  localparam logic [3:0] ID_LOW_IDX = 4'h0;
  localparam logic            LOCK_RST = 1'b0;
  localparam logic            NO_AUTO_RETRANSMIT_RST = 1'b0;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;
  // ======================================
  // Sequencer states
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_PREP  = 4'h2,
    TX_BUSY  = 4'h4,
    TX_SPACE = 4'h8
  } tx_state_type;
endpackage

// >>> core/tx_engine.sv
// Transmit sequencer: preparation window, frame, quiet gap
`timescale 1ns/100ps
module tx_engine
  import msgbuf_pkg::*;
(
  input wire logic clk,  // System clock
  input wire logic rst,  // Async reset, high
  input wire logic ce,   // Clock enable
  buf_link_if.eng  link  // Control link
);
  tx_state_type     state; // Sequencer state
  logic [CNT_W-1:0] cnt;   // Cycle countdown

  assign link.in_prep = (state == TX_PREP);
  assign link.busy    = (state == TX_BUSY);
  assign link.idle    = (state == TX_IDLE) || (state == TX_SPACE);

  // State and countdown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= TX_IDLE;
      cnt   <= '0;
    end else if (ce) begin
      case (state)
        TX_IDLE: begin
          if (link.start) begin
            state <= TX_PREP;
            cnt   <= PREP_LAST;
          end
        end
        TX_PREP: begin
          if (link.cancel) begin
            state <= TX_IDLE;
          end else if (cnt == '0) begin
            state <= TX_BUSY;
          end else begin
            cnt <= cnt - CNT_ONE;
          end
        end
        TX_BUSY: begin
          // Gap keeps a lock clear after busy falls clear of the window
          if (link.done || link.fail) begin
            state <= TX_SPACE;
            cnt   <= SPACE_LAST;
          end
        end
        TX_SPACE: begin
          if (cnt == '0) begin
            state <= TX_IDLE;
          end else begin
            cnt <= cnt - CNT_ONE;
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  // One-cycle event pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.sof      <= 1'b0;
      link.att_ok   <= 1'b0;
      link.att_fail <= 1'b0;
    end else if (ce) begin
      link.sof      <= link.in_prep && !link.cancel && cnt == '0;
      link.att_ok   <= link.busy && link.done;
      link.att_fail <= link.busy && link.fail && !link.done;
    end
  end

  sequence s_prep_end;
    link.in_prep && !link.cancel && cnt == '0;
  endsequence
  property p_sof;
    @(posedge clk) disable iff (rst || !ce) s_prep_end |=> link.sof && link.busy;
  endproperty
  a_sof: assert property (p_sof) else $error("no frame after preparation");
  property p_gap;
    @(posedge clk) disable iff (rst || !ce) $fell(link.busy) |-> !link.in_prep [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("preparation too soon after busy");
  property p_cancel;
    @(posedge clk) disable iff (rst || !ce)
      link.in_prep && link.cancel |=> link.idle && !link.sof;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel did not stop");
endmodule

// >>> test/can_far_model.sv
// Model of the CAN core and far nodes ending each frame
`timescale 1ns/100ps
module can_far_model #(
  parameter int FRAME_CYCLES = 60 // Frame length on the bus
) (
  input  wire logic clk,          // System clock
  input  wire logic rst,          // Async reset, high
  input  wire logic tx_busy,      // Frame on the bus
  input  wire logic fail_mode,    // End the frame with an error
  output logic      core_tx_done, // Frame sent well
  output logic      core_tx_fail  // Error or lost arbitration
);
  // =====
  // Frame timer
  int unsigned cnt; // Cycles into the current frame
  // One end pulse per frame; the counter parks so a long busy gives no second pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt          <= 0;
      core_tx_done <= 1'b0;
      core_tx_fail <= 1'b0;
    end else begin
      core_tx_done <= 1'b0;
      core_tx_fail <= 1'b0;
      if (!tx_busy) begin
        cnt <= 0;
      end else if (cnt < FRAME_CYCLES) begin
        cnt <= cnt + 1;
        if (cnt == FRAME_CYCLES - 1) begin
          core_tx_done <= !fail_mode;
          core_tx_fail <= fail_mode;
        end
      end
    end
  end
endmodule

// >>> test/test_can_message_buffer_tx_abort.sv
// Self-checking bench for the CAN message buffer
`timescale 1ns/100ps
module test_can_message_buffer_tx_abort;
  import msgbuf_pkg::*;
  // =====
  // Stimulus and observed signals
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1;        // Clock, reset, enable
  logic        avs_read = 1'b0, avs_write = 1'b0;         // Bus strobes
  logic [5:0]  avs_address = 6'h00;                       // Bus address
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;    // Bus data
  logic [3:0]  avs_byteenable = 4'hF, core_rd_idx = 4'h0; // Lanes, core index
  logic [3:0]  rx_idx = 4'h0;                             // Receive index
  logic [7:0]  rx_byte = 8'h00, core_rd_byte, rnd = 8'h0F, id; // Bytes
  logic        bus_idle = 1'b0, other_pending = 1'b0;     // Core status
  logic        rx_we = 1'b0, rx_last = 1'b0, fail_mode = 1'b0; // Receive, far side
  logic        avs_waitrequest, core_tx_done, core_tx_fail; // Answers
  logic        frame_start, send_page0, tx_busy, irq;    // Design outputs
  int          err_total = 0, checks = 0, cycles = 0;    // Counters
  can_message_buffer_tx_abort can_message_buffer_tx_abort_inst (.clk(clk), .rst(rst),
    .ce(ce), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus_idle(bus_idle),
    .other_pending(other_pending), .core_tx_done(core_tx_done),
    .core_tx_fail(core_tx_fail), .core_rd_idx(core_rd_idx), .core_rd_byte(core_rd_byte),
    .rx_we(rx_we), .rx_idx(rx_idx), .rx_byte(rx_byte), .rx_last(rx_last),
    .frame_start(frame_start), .send_page0(send_page0), .tx_busy(tx_busy), .irq(irq));
  can_far_model can_far_model_inst (.clk(clk), .rst(rst), .tx_busy(tx_busy),
    .fail_mode(fail_mode), .core_tx_done(core_tx_done), .core_tx_fail(core_tx_fail));
  // =====
  // Clock and hang guard; the run needs a few thousand cycles
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end
  // =====
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // Identifier low as read back: over-long length is held at eight
  function automatic logic [31:0] id_exp(input logic [7:0] v);
    return {24'h0, v[7:4], (v[3:0] > DLC_MAX) ? DLC_MAX : v[3:0]};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Avalon cycle: request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input string n, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  // One received byte into the identifier low slot, closing the message
  task automatic rx(input logic [7:0] b);
    rx_idx  <= ID_LOW_IDX;
    rx_byte <= b;
    rx_we   <= 1'b1;
    rx_last <= 1'b1;
    @(posedge clk);
    rx_we   <= 1'b0;
    rx_last <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_busy(input logic v);
    while (tx_busy !== v) @(posedge clk);
  endtask
  // =====
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("buf ctrl", OFS_BUF_CTRL, 32'h0);
    rd("irq mask", OFS_IRQ_MASK, 32'h0);
    rd("unmapped", 6'h3C, 32'h0);
    // Random fields, with a length of nine and a remote frame first
    for (int i = 0; i < 14; i++) begin
      rnd = lfsr(rnd);
      id = (i == 0) ? 8'hF9 : (i == 1) ? 8'h18 : rnd;
      wr(OFS_ID_LOW, {24'h0, id});
      rd("id low", OFS_ID_LOW, id_exp(id));
      wr(6'h04 + 6'(4 * (i % 7)), {24'h0, rnd});
      rd("data", 6'h04 + 6'(4 * (i % 7)), {24'h0, rnd});
    end
    core_rd_idx <= ID_LOW_IDX;
    repeat (2) @(posedge clk);
    chk("core byte", id_exp(id), {24'h0, core_rd_byte});
    // Reception while unlocked, then blocked by the lock
    rx(8'h35);
    rd("rx store", OFS_ID_LOW, 32'h35);
    rd("rx event", OFS_IRQ_STATUS, 32'h8);
    wr(OFS_BUF_CTRL, 32'h1);
    rx(8'hA2);
    rd("rx locked", OFS_ID_LOW, 32'h35);
    // Pending request with the bus held busy, then cancelled
    wr(OFS_IRQ_STATUS, 32'hF);
    wr(OFS_LAST_DATA_BYTE, 32'h5A);
    rd("ready set", OFS_BUF_CTRL, 32'h3);
    wr(OFS_BUF_CTRL, 32'h0);
    rd("cancel", OFS_BUF_CTRL, 32'h0);
    rd("abort ev", OFS_IRQ_STATUS, 32'h2);
    // Successful frame with interrupt raised, masked and cleared
    wr(OFS_IRQ_STATUS, 32'hF);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_BUF_CTRL, 32'h1);
    bus_idle <= 1'b1;
    wr(OFS_LAST_DATA_BYTE, 32'hC3);
    wait_busy(1'b1);
    chk("sof", 32'h1, {31'h0, frame_start});
    wait_busy(1'b0);
    repeat (3) @(posedge clk);
    rd("tx done", OFS_BUF_CTRL, 32'h1);
    rd("tx ok ev", OFS_IRQ_STATUS, 32'h1);
    chk("irq on", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq mask", 32'h0, {31'h0, irq});
    wr(OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clr", 32'h0, {31'h0, irq});
    // Lock cleared in mid-frame: frame runs on, a second clear aborts
    repeat (250) @(posedge clk);
    wr(OFS_CTRL, 32'h1);
    fail_mode <= 1'b1;
    wr(OFS_IRQ_STATUS, 32'hF);
    wr(OFS_LAST_DATA_BYTE, 32'h11);
    wait_busy(1'b1);
    wr(OFS_BUF_CTRL, 32'h0);
    chk("busy kept", 32'h1, {31'h0, tx_busy});
    wait_busy(1'b0);
    repeat (2) @(posedge clk);
    rd("ready kept", OFS_BUF_CTRL, 32'h2);
    wr(OFS_BUF_CTRL, 32'h0);
    rd("abort", OFS_BUF_CTRL, 32'h0);
    rd("fail ev", OFS_IRQ_STATUS, 32'h6);
    wr(OFS_CTRL, 32'h0);
    fail_mode <= 1'b0;
    // Lock cleared in preparation, alone and with another request waiting
    for (int op = 0; op < 2; op++) begin
      repeat (250) @(posedge clk);
      other_pending <= op[0];
      wr(OFS_BUF_CTRL, 32'h1);
      wr(OFS_LAST_DATA_BYTE, 32'h22);
      repeat (20) @(posedge clk);
      wr(OFS_BUF_CTRL, 32'h0);
      if (op == 1) begin
        repeat (200) @(posedge clk);
        chk("no frame", 32'h0, {31'h0, tx_busy});
      end else begin
        wait_busy(1'b1);
        chk("page zero", 32'h1, {31'h0, send_page0});
        wait_busy(1'b0);
        repeat (2) @(posedge clk);
      end
      rd("prep clr", OFS_BUF_CTRL, 32'h0);
    end
    close_out();
  end
endmodule
